// file: core/rais_pkg.sv
// Shared constants and types of the reset and interrupt sequencer
package rais_pkg;
	// ------------------------------------------------------------
	// Timing counts, in core clock cycles
	// ------------------------------------------------------------
	localparam int RST_CYC   = 4096;
	localparam int STAB_CYC  = 4096;
	localparam int GUARD_CYC = 4;
	localparam int CTX_BYTES = 5;
	localparam int POP_END   = CTX_BYTES + 2;

	// ------------------------------------------------------------
	// Request sources
	// ------------------------------------------------------------
	localparam int              EXT0_W   = 8;
	localparam int              EXT1_W   = 14;
	localparam int              EXT_MAX  = 14;
	localparam int              NPER     = 12;
	localparam logic [NPER-1:0] PER_HALT = 12'h000;

	// ------------------------------------------------------------
	// Vectors, sense codes, stack layout
	// ------------------------------------------------------------
	localparam logic [15:0] VEC_RESET      = 16'hfffe;
	localparam logic [15:0] VEC_TRAP       = 16'hfffc;
	localparam logic [15:0] VEC_EXT0       = 16'hfffa;
	localparam int          MASK_BIT       = 3;
	localparam logic [1:0]  SENSE_FALL_LOW = 2'h0;
	localparam logic [1:0]  SENSE_FALL     = 2'h2;
	localparam logic [1:0]  SENSE_RISE     = 2'h1;
	localparam logic [1:0]  SENSE_BOTH     = 2'h3;
	localparam logic [2:0]  SEL_PCL        = 3'h0;
	localparam logic [2:0]  SEL_PCH        = 3'h1;
	localparam logic [2:0]  SEL_X          = 3'h2;
	localparam logic [2:0]  SEL_A          = 3'h3;
	localparam logic [2:0]  SEL_FLAGS      = 3'h4;

	typedef enum logic [7:0] {
		ST_RESET = 8'h01,
		ST_STAB  = 8'h02,
		ST_RUN   = 8'h04,
		ST_PUSH  = 8'h08,
		ST_VEC   = 8'h10,
		ST_POP   = 8'h20,
		ST_WAIT  = 8'h40,
		ST_HALT  = 8'h80
	} rais_state_t;

	typedef struct packed {
		logic [15:0] pc;
		logic [7:0]  x;
		logic [7:0]  a;
		logic [7:0]  flags;
	} rais_ctx_t;
endpackage

// file: core/rais_core.sv
// Reset sequencer and interrupt arbiter for the 8-bit core
//
// Overview of operation
// - Reset is entered from the reset pin, power-on detection or watchdog.
// - Leaving reset, the program counter is loaded from vector FFFEh.
// - Internal reset sources pull the open-drain reset pin low for the span.
// - Reset lasts at least 4096 cycles; o_sys_rst_n and o_cpu_run stay low throughout.
// - A low reset pin is caught without the clock, even in halt.
// - A reset pin still held low keeps the device in reset.
// - After reset or halt exit, 4096 cycles pass before the CPU resumes.
// - Maskable requests are serviced only with mask_flag clear; others wait latched.
// - Service pushes PC, X, A, flags_reg, sets mask_flag, loads vector.
// - isr_exit pops the context, restoring mask_flag from the popped flags byte and resuming.
// - Simultaneous requests are chosen by a fixed priority.
// - soft_break is serviced regardless of mask_flag.
// - Any request wakes from wait; only halt-capable ones wake from halt.
// - An external pin edge request is latched and cleared on entering its service.
// - Shared pins of one external vector are ANDed before detection.
// - A low shared pin suppresses the request in rising mode only.
// - Second group sensitivity follows the edge_sense_sel setting, the first group follows i_ext0_sense.
// - Peripheral flags request only when enabled and unmasked, else stay pending.
// - Software clears a peripheral request by its clear sequence.
// - The clear sequence drops the latch, discarding a pending request.
// - Sense codes: 00 fall plus low, 10 fall, 01 rise, 11 both.
// - Changing a sense setting clears that vector's pending request.
// - First pin group uses vector FFFAh and can exit halt.
`timescale 1ns/1ps
module rais_core #(
	parameter int                RST_CYC   = rais_pkg::RST_CYC,
	parameter int                STAB_CYC  = rais_pkg::STAB_CYC,
	parameter int                NPER      = rais_pkg::NPER,
	parameter logic [NPER-1:0]   PER_HALT  = rais_pkg::PER_HALT
) (
	input  wire logic                         i_core_clk,         // Core clock
	input  wire logic                         i_rst_n,            // Sync reset, low active
	input  wire logic                         i_rst_pin,          // Reset pad level
	output logic                              o_rst_pin_out,      // Reset pad drive value
	output logic                              o_rst_pin_oe_n,     // Reset pad drive, low = driving
	input  wire logic                         i_por,              // Power-on pulse
	input  wire logic                         i_wdg_rst,          // Watchdog reset pulse
	output logic                              o_sys_rst_n,        // System reset, low active
	output logic                              o_osc_en,           // Oscillator enable
	output logic                              o_cpu_run,          // CPU may execute
	input  wire logic [rais_pkg::EXT0_W-1:0]  i_ext0_pin,         // First group pins
	input  wire logic [rais_pkg::EXT0_W-1:0]  i_ext0_ie,          // First group pin enables
	input  wire logic [1:0]                   i_ext0_sense,       // First group sense code
	input  wire logic [rais_pkg::EXT1_W-1:0]  i_pin_irq_group,    // Second group pins
	input  wire logic [rais_pkg::EXT1_W-1:0]  i_pin_irq_group_ie, // Second group pin enables
	input  wire logic [1:0]                   i_edge_sense_sel,   // Second group sense code
	input  wire logic [NPER-1:0]              i_per_flag,         // Peripheral flags
	input  wire logic [NPER-1:0]              i_per_en,           // Peripheral enables
	input  wire logic [NPER-1:0]              i_per_clr,          // Clear sequence pulses
	input  wire logic                         i_instr_end,        // Instruction boundary
	input  wire logic                         i_trap,             // soft_break executed
	input  wire logic                         i_isr_exit,         // isr_exit executed
	input  wire logic                         i_mask_set,         // Set mask_flag
	input  wire logic                         i_mask_clr,         // Clear mask_flag
	input  wire logic                         i_wait_enter,       // Wait instruction
	input  wire logic                         i_halt_enter,       // Halt instruction
	input  wire rais_pkg::rais_ctx_t          i_ctx,              // CPU context to save
	output logic                              o_mask_flag,        // mask_flag
	output logic                              o_pc_load,          // Load PC pulse
	output logic [15:0]                       o_pc_vec,           // Vector address
	output logic                              o_stk_we,           // Stack push strobe
	output logic [7:0]                        o_stk_wdata,        // Stack push byte
	output logic                              o_stk_re,           // Stack pop strobe
	input  wire logic [7:0]                   i_stk_rdata,        // Pop byte, cycle after o_stk_re
	output logic                              o_rest_we,          // Restore strobe
	output logic [2:0]                        o_rest_sel,         // Restored register
	output logic [7:0]                        o_rest_data         // Restored byte
);
	localparam int NREQ  = NPER + 2;
	localparam int SEL_W = $clog2(NREQ);
	localparam int CNT_W = $clog2(RST_CYC > STAB_CYC ? RST_CYC : STAB_CYC) + 1;
	localparam logic [CNT_W-1:0] RST_LAST  = CNT_W'(RST_CYC - 1);
	localparam logic [CNT_W-1:0] STAB_LAST = CNT_W'(STAB_CYC - 1);

	rais_pkg::rais_state_t st_r;
	rais_pkg::rais_ctx_t   ctx_r;
	logic [CNT_W-1:0]      cnt_r;
	logic [15:0]           vec_r;
	logic                  rstp_r, drive_r, mask_r, trap_r, re_d_r;
	logic [2:0]            grd_r, cap_k_r;
	logic                  pin_low_a, pin_s1_r, pin_s2_r, por_s1_r, por_s2_r;
	logic                  in_reset, in_stab, in_run, in_pop, in_wait, in_halt;
	logic                  ext_rst, int_rst, rst_src, take, svc_go, svc_trap, cap_cc;
	logic [1:0]            ext_lat_r, ext_evt, ext_req, sense_chg, svc_clr;
	logic [NPER-1:0]       per_lat_r, flag_d_r;
	logic [NREQ-1:0]       reqs;
	logic [SEL_W-1:0]      sel;
	logic [15:0]           svc_vec;
	logic [7:0]            push_byte;
	logic [1:0][rais_pkg::EXT_MAX-1:0] ext_pin, ext_ie;
	logic [1:0][1:0]                   ext_sense;

	assign in_reset = st_r == rais_pkg::ST_RESET;
	assign in_stab  = st_r == rais_pkg::ST_STAB;
	assign in_run   = st_r == rais_pkg::ST_RUN;
	assign in_pop   = st_r == rais_pkg::ST_POP;
	assign in_wait  = st_r == rais_pkg::ST_WAIT;
	assign in_halt  = st_r == rais_pkg::ST_HALT;

	// ------------------------------------------------------------
	// Reset sources
	// ------------------------------------------------------------
	// Pad low sets this flop with no clock edge, so halt cannot hide it
	always_ff @(posedge i_core_clk or negedge i_rst_pin) begin
		if (!i_rst_pin) begin
			pin_low_a <= 1'b1;
		end else begin
			pin_low_a <= 1'b0;
		end
	end

	always_ff @(posedge i_core_clk) begin
		pin_s1_r <= pin_low_a;
		pin_s2_r <= pin_s1_r;
		por_s1_r <= i_por;
		por_s2_r <= por_s1_r;
	end

	// Own drive reads back low; guard masks it until the sync has drained
	assign ext_rst = pin_s2_r & ~drive_r & (grd_r == 3'h0);
	assign int_rst = por_s2_r | i_wdg_rst;
	assign rst_src = ext_rst | int_rst;

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			drive_r <= 1'b0;
			grd_r   <= 3'h0;
		end else if (int_rst) begin
			drive_r <= 1'b1;
		end else if (drive_r && in_reset && cnt_r == RST_LAST) begin
			drive_r <= 1'b0;
			grd_r   <= 3'(rais_pkg::GUARD_CYC);
		end else if (grd_r != 3'h0) begin
			grd_r <= grd_r - 3'h1;
		end
	end

	// ------------------------------------------------------------
	// External request groups
	// ------------------------------------------------------------
	// Unused high pins padded high with enables low, so they never mask
	assign ext_pin[0]   = {{(rais_pkg::EXT_MAX - rais_pkg::EXT0_W){1'b1}}, i_ext0_pin};
	assign ext_ie[0]    = {{(rais_pkg::EXT_MAX - rais_pkg::EXT0_W){1'b0}}, i_ext0_ie};
	assign ext_pin[1]   = i_pin_irq_group;
	assign ext_ie[1]    = i_pin_irq_group_ie;
	assign ext_sense[0] = i_ext0_sense;
	assign ext_sense[1] = i_edge_sense_sel;

	genvar g;
	for (g = 0; g < 2; g++) begin : g_ext
		logic [rais_pkg::EXT_MAX-1:0] s1_r, s2_r;
		logic                         lvl, act, lvl_d_r, fall, rise;
		logic [1:0]                   sns_d_r;

		always_ff @(posedge i_core_clk) begin
			s1_r <= ext_pin[g];
			s2_r <= s1_r;
		end

		assign lvl  = &(s2_r | ~ext_ie[g]);
		assign act  = |ext_ie[g];
		assign fall = act & lvl_d_r & ~lvl;
		assign rise = act & ~lvl_d_r & lvl;
		assign sense_chg[g] = ext_sense[g] != sns_d_r;
		assign svc_clr[g]   = svc_go & ~svc_trap & (sel == SEL_W'(g));

		always_comb begin
			unique case (ext_sense[g])
				rais_pkg::SENSE_FALL_LOW,
				rais_pkg::SENSE_FALL: ext_evt[g] = fall;
				rais_pkg::SENSE_RISE: ext_evt[g] = rise;
				rais_pkg::SENSE_BOTH: ext_evt[g] = fall | rise;
			endcase
		end

		always_comb begin
			if (ext_sense[g] == rais_pkg::SENSE_FALL_LOW) begin
				ext_req[g] = ext_lat_r[g] | (act & ~lvl);
			end else if (ext_sense[g] == rais_pkg::SENSE_RISE) begin
				ext_req[g] = ext_lat_r[g] & lvl;
			end else begin
				ext_req[g] = ext_lat_r[g];
			end
		end

		always_ff @(posedge i_core_clk) begin
			if (!i_rst_n || in_reset) begin
				ext_lat_r[g] <= 1'b0;
				lvl_d_r      <= 1'b1;
				sns_d_r      <= rais_pkg::SENSE_FALL_LOW;
			end else begin
				ext_lat_r[g] <= ext_evt[g] | (ext_lat_r[g] & ~(sense_chg[g] | svc_clr[g]));
				lvl_d_r      <= lvl;
				sns_d_r      <= ext_sense[g];
			end
		end
	end

	// ------------------------------------------------------------
	// Peripheral requests and arbitration
	// ------------------------------------------------------------
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n || in_reset) begin
			per_lat_r <= '0;
			flag_d_r  <= '0;
			trap_r    <= 1'b0;
		end else begin
			per_lat_r <= (i_per_flag & ~flag_d_r) | (per_lat_r & ~i_per_clr);
			flag_d_r  <= i_per_flag;
			trap_r    <= (i_trap | trap_r) & ~svc_trap;
		end
	end

	assign reqs = {per_lat_r & i_per_en, ext_req};

	// Lowest index is the highest vector, so it wins
	always_comb begin
		sel = '0;
		for (int i = NREQ - 1; i >= 0; i--) begin
			if (reqs[i]) begin
				sel = SEL_W'(i);
			end
		end
	end

	assign take     = (in_run & i_instr_end & ~i_isr_exit) | in_wait | (in_stab & cnt_r == STAB_LAST & ~rstp_r);
	assign svc_trap = in_run & take & (trap_r | i_trap);
	assign svc_go   = ~rst_src & take & (svc_trap | (|reqs & ~mask_r));
	assign svc_vec  = svc_trap ? rais_pkg::VEC_TRAP : rais_pkg::VEC_EXT0 - 16'({sel, 1'b0});

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			st_r   <= rais_pkg::ST_RESET;
			cnt_r  <= '0;
			rstp_r <= 1'b1;
			vec_r  <= rais_pkg::VEC_RESET;
			ctx_r  <= '0;
		end else if (rst_src) begin
			st_r   <= rais_pkg::ST_RESET;
			cnt_r  <= '0;
			rstp_r <= 1'b1;
		end else if (svc_go) begin
			st_r  <= rais_pkg::ST_PUSH;
			cnt_r <= '0;
			vec_r <= svc_vec;
			ctx_r <= i_ctx;
		end else begin
			unique case (st_r)
				rais_pkg::ST_RESET: begin
					if (cnt_r == RST_LAST) begin
						st_r  <= rais_pkg::ST_STAB;
						cnt_r <= '0;
					end else begin
						cnt_r <= cnt_r + 1'b1;
					end
				end
				rais_pkg::ST_STAB: begin
					if (cnt_r == STAB_LAST) begin
						st_r  <= rstp_r ? rais_pkg::ST_VEC : rais_pkg::ST_RUN;
						vec_r <= rais_pkg::VEC_RESET;
						cnt_r <= '0;
					end else begin
						cnt_r <= cnt_r + 1'b1;
					end
				end
				rais_pkg::ST_RUN: begin
					if (i_isr_exit) begin
						st_r  <= rais_pkg::ST_POP;
						cnt_r <= '0;
					end else if (i_wait_enter) begin
						st_r <= rais_pkg::ST_WAIT;
					end else if (i_halt_enter) begin
						st_r <= rais_pkg::ST_HALT;
					end
				end
				rais_pkg::ST_PUSH: begin
					if (cnt_r == CNT_W'(rais_pkg::CTX_BYTES - 1)) begin
						st_r <= rais_pkg::ST_VEC;
					end else begin
						cnt_r <= cnt_r + 1'b1;
					end
				end
				rais_pkg::ST_VEC: begin
					st_r   <= rais_pkg::ST_RUN;
					rstp_r <= 1'b0;
				end
				rais_pkg::ST_POP: begin
					if (cnt_r == CNT_W'(rais_pkg::POP_END)) begin
						st_r <= rais_pkg::ST_RUN;
					end else begin
						cnt_r <= cnt_r + 1'b1;
					end
				end
				rais_pkg::ST_WAIT: begin
				end
				rais_pkg::ST_HALT: begin
					if (|(reqs & {PER_HALT, 2'h3})) begin
						st_r  <= rais_pkg::ST_STAB;
						cnt_r <= '0;
					end
				end
			endcase
		end
	end

	assign cap_cc = in_pop & re_d_r & (cap_k_r == 3'h0);

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n || in_reset) begin
			mask_r <= 1'b1;
		end else if (cap_cc) begin
			mask_r <= i_stk_rdata[rais_pkg::MASK_BIT];
		end else if (svc_go) begin
			mask_r <= 1'b1;
		end else if (in_run && !i_isr_exit && (i_wait_enter || i_halt_enter)) begin
			mask_r <= 1'b0;
		end else if (i_mask_set) begin
			mask_r <= 1'b1;
		end else if (i_mask_clr) begin
			mask_r <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	always_comb begin
		unique case (cnt_r[2:0])
			rais_pkg::SEL_PCL: push_byte = ctx_r.pc[7:0];
			rais_pkg::SEL_PCH: push_byte = ctx_r.pc[15:8];
			rais_pkg::SEL_X:   push_byte = ctx_r.x;
			rais_pkg::SEL_A:   push_byte = ctx_r.a;
			default:           push_byte = ctx_r.flags;
		endcase
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			o_sys_rst_n    <= 1'b0;
			o_osc_en       <= 1'b1;
			o_cpu_run      <= 1'b0;
			o_rst_pin_oe_n <= 1'b1;
			o_rst_pin_out  <= 1'b0;
			o_mask_flag    <= 1'b1;
			o_pc_load      <= 1'b0;
			o_pc_vec       <= rais_pkg::VEC_RESET;
			o_stk_we       <= 1'b0;
			o_stk_wdata    <= 8'h00;
			o_stk_re       <= 1'b0;
		end else begin
			o_sys_rst_n    <= ~in_reset;
			o_osc_en       <= ~in_halt;
			o_cpu_run      <= in_run;
			o_rst_pin_oe_n <= ~drive_r;
			o_rst_pin_out  <= 1'b0;
			o_mask_flag    <= mask_r;
			o_pc_load      <= st_r == rais_pkg::ST_VEC;
			o_pc_vec       <= vec_r;
			o_stk_we       <= st_r == rais_pkg::ST_PUSH;
			o_stk_wdata    <= push_byte;
			o_stk_re       <= in_pop && cnt_r < CNT_W'(rais_pkg::CTX_BYTES);
		end
	end

	// Pop order is flags, A, X, PCH, PCL
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			re_d_r      <= 1'b0;
			cap_k_r     <= 3'h0;
			o_rest_we   <= 1'b0;
			o_rest_sel  <= rais_pkg::SEL_FLAGS;
			o_rest_data <= 8'h00;
		end else begin
			re_d_r      <= o_stk_re;
			cap_k_r     <= !in_pop ? 3'h0 : cap_k_r + 3'(re_d_r);
			o_rest_we   <= re_d_r;
			o_rest_sel  <= rais_pkg::SEL_FLAGS - cap_k_r;
			o_rest_data <= i_stk_rdata;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	chk_rst_min_len: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(in_reset ##1 in_stab) |-> $past(cnt_r) == RST_LAST)
		else $error("reset left before full length");
	chk_stab_len: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(in_stab && !rst_src ##1 !in_stab) |-> $past(cnt_r) == STAB_LAST)
		else $error("stabilisation delay too short");
	chk_reset_vector: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(in_stab && rstp_r && cnt_r == STAB_LAST && !rst_src) |-> ##2 o_pc_load && o_pc_vec == rais_pkg::VEC_RESET)
		else $error("reset vector not loaded");
	chk_pin_drive: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		int_rst |-> ##[1:2] !o_rst_pin_oe_n)
		else $error("reset pin not driven for internal reset");
	chk_mask_gate: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(in_run && mask_r && !i_trap && !trap_r) |=> st_r != rais_pkg::ST_PUSH)
		else $error("maskable request taken while masked");
	chk_service_mask: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		svc_go |=> mask_r && st_r == rais_pkg::ST_PUSH && vec_r == $past(svc_vec))
		else $error("service entry wrong");
	chk_trap_nomask: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(in_run && i_instr_end && i_trap && !i_isr_exit && !rst_src) |=> vec_r == rais_pkg::VEC_TRAP)
		else $error("trap not serviced");
	chk_edge_clear: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(svc_clr[0] && !ext_evt[0]) |=> !ext_lat_r[0])
		else $error("edge latch not cleared on service");
	chk_sense_clear: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(!in_reset && sense_chg[1] && !ext_evt[1]) |=> !ext_lat_r[1])
		else $error("sense change kept pending request");
	chk_reset_clears: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		in_reset |=> ext_lat_r == 2'h0 && per_lat_r == '0 && !trap_r)
		else $error("latch survived reset");
	chk_wait_wake: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(in_wait && |reqs && !mask_r && !rst_src) |=> st_r == rais_pkg::ST_PUSH)
		else $error("request did not wake from wait");
endmodule

// file: sim/rais_cpu_model.sv
// Stack memory of the core, answering the sequencer's push and pop strobes
`timescale 1ns/1ps
module rais_cpu_model (
	input  wire logic       i_core_clk,  // Core clock
	input  wire logic       i_stk_we,    // Push strobe
	input  wire logic [7:0] i_stk_wdata, // Push byte
	input  wire logic       i_stk_re,    // Pop strobe
	output logic [7:0]      o_stk_rdata  // Pop byte, cycle after strobe
);
	logic [7:0] mem [0:7];
	logic [2:0] sp_r = 3'h0;
	initial o_stk_rdata = 8'h00;
	// Newest byte pops first, so flags come back before the PC
	always @(posedge i_core_clk) begin
		if (i_stk_we) begin
			mem[sp_r] <= i_stk_wdata;
			sp_r <= sp_r + 3'h1;
		end else if (i_stk_re) begin
			o_stk_rdata <= mem[sp_r - 3'h1];
			sp_r <= sp_r - 3'h1;
		end else begin
			// Stale byte must never look valid
			o_stk_rdata <= ~o_stk_rdata;
		end
	end
endmodule

// file: sim/rais_core_tb.sv
// Self-checking bench of the reset and interrupt sequencer
`timescale 1ns/1ps
module rais_core_tb;
	typedef struct packed {logic [1:0] kind; logic [3:0] idx; logic [1:0] sense; logic [15:0] vec;} rais_row_t;
	localparam int RC = 16;
	rais_row_t rows [8] = '{'{2'h0, 4'h0, 2'h0, 16'hfffc}, '{2'h1, 4'h0, 2'h0, 16'hfffa},
		'{2'h2, 4'h0, 2'h0, 16'hfff8}, '{2'h2, 4'h0, 2'h2, 16'hfff8}, '{2'h2, 4'h0, 2'h1, 16'hfff8},
		'{2'h2, 4'h0, 2'h3, 16'hfff8}, '{2'h3, 4'h0, 2'h0, 16'hfff6}, '{2'h3, 4'h3, 2'h0, 16'hfff0}};
	logic clk, rst_n, ext_low, por, iend, trap, iexit, mset, mclr, hent, got, wen, wdg;
	logic [7:0] rest_seen [5];
	logic out, oe_n, sys_rst_n, osc_en, cpu_run, mask, pc_load, stk_we, stk_re, rest_we;
	logic [7:0] ext0, wdata, rdata, rest_data;
	logic [13:0] grp;
	logic [1:0] s1;
	logic [11:0] pflag, pen, pclr;
	logic [15:0] pc_vec;
	logic [2:0] rest_sel;
	rais_pkg::rais_ctx_t ctx;
	int fails = 0;
	int comparisons = 0;
	int cyc = 0;
	// Pull-up unless someone pulls low
	wire rst_pin = !(ext_low || (!oe_n && !out));

	rais_core #(.RST_CYC(RC), .STAB_CYC(RC)) dut (.i_core_clk(clk), .i_rst_n(rst_n), .i_rst_pin(rst_pin),
		.o_rst_pin_out(out), .o_rst_pin_oe_n(oe_n), .i_por(por), .i_wdg_rst(wdg), .o_sys_rst_n(sys_rst_n),
		.o_osc_en(osc_en), .o_cpu_run(cpu_run), .i_ext0_pin(ext0), .i_ext0_ie(8'h03), .i_ext0_sense(2'h0),
		.i_pin_irq_group(grp), .i_pin_irq_group_ie(14'h0003), .i_edge_sense_sel(s1), .i_per_flag(pflag),
		.i_per_en(pen), .i_per_clr(pclr), .i_instr_end(iend), .i_trap(trap), .i_isr_exit(iexit),
		.i_mask_set(mset), .i_mask_clr(mclr), .i_wait_enter(wen), .i_halt_enter(hent), .i_ctx(ctx),
		.o_mask_flag(mask), .o_pc_load(pc_load), .o_pc_vec(pc_vec), .o_stk_we(stk_we), .o_stk_wdata(wdata),
		.o_stk_re(stk_re), .i_stk_rdata(rdata), .o_rest_we(rest_we), .o_rest_sel(rest_sel),
		.o_rest_data(rest_data));
	rais_cpu_model model (.i_core_clk(clk), .i_stk_we(stk_we), .i_stk_wdata(wdata), .i_stk_re(stk_re),
		.o_stk_rdata(rdata));

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Bounded wait for the load pulse or for the CPU to run
	task automatic wait_for(input bit run, input int lim);
		int n;
		n = 0;
		got = 1'b0;
		while (!got && n < lim) begin
			@(posedge clk);
			#1;
			got = run ? cpu_run : pc_load;
			n++;
		end
		#1;
	endtask
	task automatic poke();
		iend = 1'b1;
		tick(1);
		iend = 1'b0;
		trap = 1'b0;
	endtask
	task automatic take(input logic [15:0] v);
		poke();
		wait_for(1'b0, 20);
		check(pc_vec, v);
		check(mask, 1'b1);
		check(model.mem[0], ctx.pc[7:0]);
		check(model.mem[4], ctx.flags);
	endtask
	task automatic ret(input logic [11:0] c);
		pclr = c;
		tick(1);
		pclr = '0;
		iexit = 1'b1;
		tick(1);
		iexit = 1'b0;
		wait_for(1'b1, 20);
		check(mask, 1'b0);
		check(rest_seen[4], ctx.flags);
		check(rest_seen[0], ctx.pc[7:0]);
	endtask

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			summarize();
		end
	end
	// Restored bytes, kept by register so the pop order is checked
	always @(posedge clk) begin
		if (rest_we) begin
			rest_seen[rest_sel] <= rest_data;
		end
	end

	initial begin
		{rst_n, ext_low, por, iend, trap, iexit, mset, mclr, hent, wen, wdg, s1, pflag, pclr} = '0;
		ext0 = 8'hff;
		grp = 14'h3fff;
		pen = 12'hfff;
		ctx = {16'h1234, 8'h56, 8'h78, 8'hf0};
		tick(10);
		rst_n = 1'b1;
		wait_for(1'b1, 3 * RC + 20);
		check(pc_vec, 16'hfffe);
		check(mask, 1'b1);
		mclr = 1'b1;
		tick(1);
		mclr = 1'b0;
		foreach (rows[i]) begin
			s1 = rows[i].sense;
			tick(4);
			ext0[0] = rows[i].kind != 2'h1;
			grp[0] = rows[i].kind != 2'h2;
			pflag[rows[i].idx] = rows[i].kind == 2'h3;
			tick(4);
			ext0[0] = 1'b1;
			grp[0] = 1'b1;
			tick(4);
			trap = rows[i].kind == 2'h0;
			take(rows[i].vec);
			pflag = '0;
			ret(12'hfff);
		end
		// Masked requests wait latched, then leave by priority
		mset = 1'b1;
		tick(1);
		mset = 1'b0;
		grp[0] = 1'b0;
		pflag[1] = 1'b1;
		tick(4);
		grp[0] = 1'b1;
		tick(4);
		poke();
		wait_for(1'b0, 12);
		check(got, 1'b0);
		mclr = 1'b1;
		tick(1);
		mclr = 1'b0;
		take(16'hfff8);
		ret(12'h000);
		take(16'hfff4);
		pflag = '0;
		ret(12'hfff);
		// Clearing a request still waiting for its enable discards it
		pen[2] = 1'b0;
		pflag[2] = 1'b1;
		tick(4);
		pflag = '0;
		pclr = 12'h004;
		tick(1);
		pclr = '0;
		pen[2] = 1'b1;
		poke();
		wait_for(1'b0, 12);
		check(got, 1'b0);
		// Wait mode wakes straight into service, no instruction boundary needed
		wen = 1'b1;
		tick(1);
		wen = 1'b0;
		tick(2);
		check(cpu_run, 1'b0);
		pflag[0] = 1'b1;
		wait_for(1'b0, 20);
		check(pc_vec, 16'hfff6);
		pflag = '0;
		ret(12'hfff);
		hent = 1'b1;
		tick(1);
		hent = 1'b0;
		tick(2);
		check(osc_en, 1'b0);
		ext0[0] = 1'b0;
		tick(4);
		ext0[0] = 1'b1;
		wait_for(1'b0, RC + 30);
		check(pc_vec, 16'hfffa);
		ret(12'h000);
		por = 1'b1;
		tick(1);
		por = 1'b0;
		tick(6);
		check(sys_rst_n, 1'b0);
		check(oe_n, 1'b0);
		check(out, 1'b0);
		ext_low = 1'b1;
		tick(3 * RC);
		check(sys_rst_n, 1'b0);
		check(cpu_run, 1'b0);
		ext_low = 1'b0;
		wait_for(1'b1, 3 * RC + 20);
		check(pc_vec, 16'hfffe);
		check(mask, 1'b1);
		wdg = 1'b1;
		tick(1);
		wdg = 1'b0;
		tick(3);
		check(sys_rst_n, 1'b0);
		check(oe_n, 1'b0);
		wait_for(1'b1, 3 * RC + 20);
		check(pc_vec, 16'hfffe);
		summarize();
	end
endmodule
